// ==== logic/xfade_pkg.sv ====
// Shared constants and types for the crossfade path switch control
package xfade_pkg;

    // Register byte offsets
    localparam logic [3:0] CTRL_OFFSET   = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;

    // Control register fields and reset value
    localparam int          CTRL_CONT_BIT = 0;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

    // Status register field positions
    localparam int STAT_LAMP_L_BIT  = 0;
    localparam int STAT_LAMP_R_BIT  = 1;
    localparam int STAT_LAMP_BY_BIT = 2;
    localparam int STAT_LAMP_AU_BIT = 3;
    localparam int STAT_LOCK_BIT    = 4;
    localparam int STAT_SIDE_BIT    = 5;
    localparam int STAT_SW_L_BIT    = 6;
    localparam int STAT_SW_R_BIT    = 7;
    localparam int STAT_FAULT_BIT   = 8;
    localparam int STAT_DIRECT_BIT  = 9;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    // Debounce settle time
    localparam int CLK_FREQ_HZ      = 50_000_000;
    localparam int DEBOUNCE_TIME_US = 10_000;
    localparam int DEBOUNCE_CYCLES  = (CLK_FREQ_HZ / 1_000_000) * DEBOUNCE_TIME_US;

    // One set of mode command lines
    typedef struct packed {
        logic auto_m;
        logic bypass_m;
        logic synth_l;
        logic synth_r;
    } cmd_type;

endpackage : xfade_pkg

// ==== logic/button_debouncer.sv ====
// Stable-time debouncer for a synchronised pushbutton level
`timescale 1ns/1ps
module button_debouncer
    import xfade_pkg::*;
#(
    parameter int CYCLES = DEBOUNCE_CYCLES
)
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic raw_in,
    output logic      clean_out
);
    localparam int CW = $clog2(CYCLES + 1);

    generate
        if (CYCLES < 1)
        begin : g_chk
            $error("CYCLES must be at least one");
        end
    endgenerate

    logic [CW-1:0] cnt_r;
    logic          clean_r;
    wire           differ  = raw_in != clean_r;
    wire           settled = cnt_r == CW'(CYCLES - 1);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_r   <= '0;
            clean_r <= 1'b0;
        end
        else if (!differ)
        begin
            cnt_r <= '0;
        end
        else if (settled)
        begin
            cnt_r   <= '0;
            clean_r <= raw_in;
        end
        else
        begin
            cnt_r <= cnt_r + CW'(1);
        end
    end

    assign clean_out = clean_r;

    debounce_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (clean_r != $past(clean_r)) |-> ($past(settled) && $past(differ)))
        else $error("debounced level changed before settling");

endmodule : button_debouncer

// ==== logic/xfade_switch_ctrl.sv ====
// Crossfade path switch control with lockout and AXI4-Lite registers
// Functional notes
// - Bypass keeps active switch until ramp done
// - Synth mode turns its switch on immediately
// - Latch source: side select tracks latch
// - Direct path: external inputs drive mode lines
// - Side select always has one side active
// - Ramp done forces both switches off
// - Debounce lockout button before use
// - Each debounced press toggles lockout
// - Lockout disconnects all external inputs
// - Lamps show actual state and auto
// - Remote buttons parallel main panel buttons
// - Ramp done marks crossfade completion
// - Lockout suppresses multiple-input fault detection
`timescale 1ns/1ps
module xfade_switch_ctrl
    import xfade_pkg::*;
#(
    parameter int DEBOUNCE_CYC = DEBOUNCE_CYCLES
)
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Pins
    input  wire cmd_type     panel_cmd,
    input  wire cmd_type     remote_cmd,
    input  wire cmd_type     ext_cmd,
    input  wire logic        lockout_button,
    input  wire logic        ramp_end_detector,
    output logic             left_path_switch,
    output logic             right_path_switch,
    output logic             lamp_synth_l,
    output logic             lamp_synth_r,
    output logic             lamp_bypass,
    output logic             lamp_auto,
    output logic             lamp_lockout
);
    generate
        if (DEBOUNCE_CYC < 1)
        begin : g_chk
            $error("DEBOUNCE_CYC must be at least one");
        end
    endgenerate

    function automatic logic more_than_one(input cmd_type c);
        // Full count needed: four active inputs must still read as a fault
        more_than_one = $countones(c) > 1;
    endfunction : more_than_one

    // Two-stage synchroniser for every pin input
    localparam int SW = 14;
    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync2_r;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else
        begin
            sync1_r <= {panel_cmd, remote_cmd, ext_cmd, lockout_button, ramp_end_detector};
            sync2_r <= sync1_r;
        end
    end

    cmd_type panel_s;
    cmd_type remote_s;
    cmd_type ext_s;
    wire     lock_btn_s = sync2_r[1];
    wire     ramp_s     = sync2_r[0];
    assign panel_s  = sync2_r[13:10];
    assign remote_s = sync2_r[9:6];
    assign ext_s    = sync2_r[5:2];

    // Control register
    logic [31:0] ctrl_r;
    wire         cont_mode = ctrl_r[CTRL_CONT_BIT];

    logic lock_clean;
    logic lock_clean_d_r;
    button_debouncer #(
        .CYCLES    (DEBOUNCE_CYC)
    ) u_button_debouncer (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .raw_in    (lock_btn_s),
        .clean_out (lock_clean)
    );
    wire lock_rise = lock_clean && !lock_clean_d_r;

    logic lockout_r;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lock_clean_d_r <= 1'b0;
            lockout_r      <= 1'b0;
        end
        else
        begin
            lock_clean_d_r <= lock_clean;
            lockout_r      <= lockout_r ^ lock_rise;
        end
    end

    // Remote and main buttons in parallel
    cmd_type btn;
    assign btn = panel_s | remote_s;

    cmd_type ext_g;
    assign ext_g = lockout_r ? cmd_type'(4'h0) : ext_s;
    wire ext_active = |ext_g;
    wire fault          = !lockout_r && more_than_one(ext_s);
    wire user_to_latch  = !cont_mode && !lockout_r && !fault;
    wire direct_sel     = cont_mode && ext_active && !fault;

    cmd_type src;
    assign src = btn | (user_to_latch ? ext_g : cmd_type'(4'h0));

    // Input latches: side, synth/bypass, auto
    logic latch_left_r;
    logic latch_synth_r;
    logic latch_auto_r;
    wire  latch_left_nxt  = src.synth_l ? 1'b1 : (src.synth_r ? 1'b0 : latch_left_r);
    wire  latch_synth_nxt = (src.synth_l || src.synth_r) ? 1'b1 : (src.bypass_m ? 1'b0 : latch_synth_r);
    // Fault or auto command wins over a clearing command
    wire  auto_set        = src.auto_m || fault;
    wire  auto_clr        = src.synth_l || src.synth_r || src.bypass_m;
    wire  latch_auto_nxt  = auto_set ? 1'b1 : (auto_clr ? 1'b0 : latch_auto_r);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            latch_left_r  <= 1'b1;
            latch_synth_r <= 1'b0;
            latch_auto_r  <= 1'b0;
        end
        else
        begin
            latch_left_r  <= latch_left_nxt;
            latch_synth_r <= latch_synth_nxt;
            latch_auto_r  <= latch_auto_nxt;
        end
    end

    // Select latch or direct user lines
    cmd_type latch_lines;
    cmd_type lines;
    assign latch_lines = '{auto_m: latch_auto_r, bypass_m: !latch_synth_r,
                           synth_l: latch_synth_r && latch_left_r,
                           synth_r: latch_synth_r && !latch_left_r};
    assign lines = direct_sel ? ext_g : latch_lines;

    wire synth_active = lines.synth_l || lines.synth_r;
    // Ramp end only counts in bypass
    wire ramp_done = ramp_s && !synth_active;

    // Side select follows latch or direct lines
    // Single bit, so exactly one side active
    logic side_left_r;
    wire  direct_side    = lines.synth_l ? 1'b1 : (lines.synth_r ? 1'b0 : side_left_r);
    wire  side_left_nxt  = direct_sel ? direct_side : latch_left_r;

    // Hold in bypass, on at once in synth
    logic left_sw_r;
    logic right_sw_r;
    wire  left_sw_nxt  = ramp_done ? 1'b0 : (synth_active ? side_left_nxt : left_sw_r);
    wire  right_sw_nxt = ramp_done ? 1'b0 : (synth_active ? !side_left_nxt : right_sw_r);

    logic lamp_l_r;
    logic lamp_r_r;
    logic lamp_by_r;
    logic lamp_au_r;

    // Reset to left, lockout off, switches off
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            side_left_r <= 1'b1;
            left_sw_r   <= 1'b0;
            right_sw_r  <= 1'b0;
            lamp_l_r    <= 1'b0;
            lamp_r_r    <= 1'b0;
            lamp_by_r   <= 1'b0;
            lamp_au_r   <= 1'b0;
        end
        else
        begin
            side_left_r <= side_left_nxt;
            left_sw_r   <= left_sw_nxt;
            right_sw_r  <= right_sw_nxt;
            lamp_l_r    <= lines.synth_l;
            lamp_r_r    <= lines.synth_r;
            lamp_by_r   <= !synth_active;
            lamp_au_r   <= lines.auto_m;
        end
    end

    assign left_path_switch  = left_sw_r;
    assign right_path_switch = right_sw_r;
    assign lamp_synth_l      = lamp_l_r;
    assign lamp_synth_r      = lamp_r_r;
    assign lamp_bypass       = lamp_by_r;
    assign lamp_auto         = lamp_au_r;
    assign lamp_lockout      = lockout_r;

    // AXI4-Lite write side; address and data taken in either order
    logic       aw_ok_r;
    logic       w_ok_r;
    logic [3:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic       bvalid_r;
    logic [1:0] bresp_r;
    wire        aw_take  = s_axi_awvalid && !aw_ok_r && !bvalid_r;
    wire        w_take   = s_axi_wvalid && !w_ok_r && !bvalid_r;
    wire        wr_go    = aw_ok_r && w_ok_r;
    wire        wr_ctrl  = awaddr_r == CTRL_OFFSET;
    wire        wr_known = wr_ctrl || awaddr_r == STATUS_OFFSET;

    function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        for (int i = 0; i < 4; i++)
        begin
            old[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
        end
        apply_strb = old;
    endfunction : apply_strb

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_ok_r  <= 1'b0;
            w_ok_r   <= 1'b0;
            awaddr_r <= 4'h0;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
            ctrl_r   <= CTRL_RESET;
        end
        else
        begin
            if (aw_take)
            begin
                aw_ok_r  <= 1'b1;
                awaddr_r <= {s_axi_awaddr[3:2], 2'b00};
            end
            if (w_take)
            begin
                w_ok_r  <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_ok_r  <= 1'b0;
                w_ok_r   <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r  <= wr_known ? RESP_OKAY : RESP_DECERR;
                if (wr_ctrl)
                begin
                    ctrl_r <= apply_strb(ctrl_r, wdata_r, wstrb_r) & 32'h0000_0001;
                end
            end
            else if (bvalid_r && s_axi_bready)
            begin
                bvalid_r <= 1'b0;
            end
        end
    end

    assign s_axi_awready = !aw_ok_r && !bvalid_r;
    assign s_axi_wready  = !w_ok_r && !bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    // Read side: one cycle from address to data
    logic [31:0] status_word;
    always_comb
    begin
        status_word                   = 32'h0000_0000;
        status_word[STAT_LAMP_L_BIT]  = lamp_l_r;
        status_word[STAT_LAMP_R_BIT]  = lamp_r_r;
        status_word[STAT_LAMP_BY_BIT] = lamp_by_r;
        status_word[STAT_LAMP_AU_BIT] = lamp_au_r;
        status_word[STAT_LOCK_BIT]    = lockout_r;
        status_word[STAT_SIDE_BIT]    = side_left_r;
        status_word[STAT_SW_L_BIT]    = left_sw_r;
        status_word[STAT_SW_R_BIT]    = right_sw_r;
        status_word[STAT_FAULT_BIT]   = fault;
        status_word[STAT_DIRECT_BIT]  = direct_sel;
    end

    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    wire         ar_take = s_axi_arvalid && !rvalid_r;
    wire [3:0]   ar_word = {s_axi_araddr[3:2], 2'b00};
    wire         rd_ctrl = ar_word == CTRL_OFFSET;
    wire         rd_stat = ar_word == STATUS_OFFSET;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_ctrl ? ctrl_r : (rd_stat ? status_word : 32'h0000_0000);
            rresp_r  <= (rd_ctrl || rd_stat) ? RESP_OKAY : RESP_DECERR;
        end
        else if (rvalid_r && s_axi_rready)
        begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    bypass_hold_a: assert property (
        (!synth_active && !ramp_done && left_sw_r) |=> left_sw_r)
        else $error("left switch dropped before ramp done");

    // Synth turns one switch on next
    synth_on_a: assert property (
        (synth_active && !ramp_done) |=> (left_sw_r != right_sw_r) && (left_sw_r == side_left_r))
        else $error("synth switch not on at once");

    latch_track_a: assert property (
        !direct_sel |=> side_left_r == $past(latch_left_r))
        else $error("side select not following latch");

    direct_drive_a: assert property (
        (direct_sel && ext_g.synth_r && !ext_g.synth_l) |=> !side_left_r)
        else $error("external input did not drive side");

    one_side_a: assert property (
        !(left_sw_r && right_sw_r))
        else $error("both path switches on");

    ramp_off_a: assert property (
        ramp_done |=> !left_sw_r && !right_sw_r)
        else $error("switch on after ramp done");

    lock_toggle_a: assert property (
        lock_rise |=> lockout_r != $past(lockout_r))
        else $error("lockout did not toggle");

    lock_isolate_a: assert property (
        lockout_r |-> !direct_sel && !user_to_latch && !ext_active)
        else $error("external input passed during lockout");

    lock_nofault_a: assert property (
        lockout_r |-> !fault)
        else $error("fault detected during lockout");

    lamp_state_a: assert property (
        1'b1 |=> (lamp_by_r == !$past(synth_active)) && (lamp_au_r == $past(lines.auto_m)))
        else $error("lamps do not show actual state");

    remote_cmd_a: assert property (
        (remote_s.bypass_m && !src.synth_l && !src.synth_r) |=> !latch_synth_r)
        else $error("remote bypass ignored");

    reset_state_a: assert property (
        $past(!aresetn) |-> side_left_r && !lockout_r && !left_sw_r && !right_sw_r)
        else $error("wrong state after reset");

endmodule : xfade_switch_ctrl

// ==== tb/panel_model.sv ====
// Model of the front panel, remote panel and automation contacts
`timescale 1ns/1ps
module panel_model
    import xfade_pkg::*;
(
    input  wire logic    aclk,
    input  wire cmd_type panel_req,
    input  wire cmd_type remote_req,
    input  wire cmd_type ext_req,
    input  wire logic    lock_req,
    output cmd_type      panel_cmd,
    output cmd_type      remote_cmd,
    output cmd_type      ext_cmd,
    output logic         lockout_button
);
    logic [1:0] chatter_r;
    logic       lock_last_r;

    initial
    begin
        panel_cmd      = '0;
        remote_cmd     = '0;
        ext_cmd        = '0;
        lockout_button = 1'h0;
        chatter_r      = 2'h0;
        lock_last_r    = 1'h0;
    end

    // Contacts move just after the edge, never on it
    always @(posedge aclk)
    begin
        panel_cmd   <= panel_req;
        remote_cmd  <= remote_req;
        ext_cmd     <= ext_req;
        lock_last_r <= lock_req;
        // Real contacts chatter, so the lockout button bounces on every change
        if (lock_req != lock_last_r)
            chatter_r <= 2'h3;
        else if (chatter_r != 2'h0)
            chatter_r <= chatter_r - 2'h1;
        lockout_button <= (chatter_r != 2'h0) ? ~lockout_button : lock_req;
    end
endmodule : panel_model

// ==== tb/tb.sv ====
// Self-checking bench for the crossfade path switch control
`timescale 1ns/1ps
module tb
    import xfade_pkg::*;
;
    // Short debounce keeps the run brief
    localparam int      DB   = 4;
    localparam cmd_type NONE = 4'h0;
    localparam cmd_type SR   = 4'h1;
    localparam cmd_type SL   = 4'h2;
    localparam cmd_type BY   = 4'h4;
    localparam cmd_type AU   = 4'h8;

    logic        aclk       = 1'h0;
    logic        aresetn    = 1'h0;
    logic [3:0]  awaddr     = 4'h0;
    logic        awvalid    = 1'h0;
    logic [31:0] wdata      = 32'h0000_0000;
    logic [3:0]  wstrb      = 4'h0;
    logic        wvalid     = 1'h0;
    logic        bready     = 1'h0;
    logic [3:0]  araddr     = 4'h0;
    logic        arvalid    = 1'h0;
    logic        rready     = 1'h0;
    logic        ramp_end   = 1'h0;
    logic        lock_req   = 1'h0;
    cmd_type     panel_req  = '0;
    cmd_type     remote_req = '0;
    cmd_type     ext_req    = '0;
    cmd_type     panel_cmd, remote_cmd, ext_cmd;
    logic        awready, wready, bvalid, arready, rvalid, lockout_button;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, stat;
    logic        lsw, rsw, lamp_l, lamp_r, lamp_by, lamp_au, lamp_lk;
    int          fail_count  = 0;
    int          comparisons = 0;
    wire  [6:0]  outs = {lsw, rsw, lamp_l, lamp_r, lamp_by, lamp_au, lamp_lk};

    always #10 aclk = ~aclk;

    panel_model far_side (.aclk(aclk), .panel_req(panel_req), .remote_req(remote_req), .ext_req(ext_req),
        .lock_req(lock_req), .panel_cmd(panel_cmd), .remote_cmd(remote_cmd), .ext_cmd(ext_cmd),
        .lockout_button(lockout_button));

    xfade_switch_ctrl #(.DEBOUNCE_CYC(DB)) uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .panel_cmd(panel_cmd), .remote_cmd(remote_cmd), .ext_cmd(ext_cmd),
        .lockout_button(lockout_button), .ramp_end_detector(ramp_end), .left_path_switch(lsw),
        .right_path_switch(rsw), .lamp_synth_l(lamp_l), .lamp_synth_r(lamp_r), .lamp_bypass(lamp_by),
        .lamp_auto(lamp_au), .lamp_lockout(lamp_lk));

    task automatic summarize();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
            fail_count++;
        end
    endtask : check

    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 100)
        begin
            $display("MISMATCH at %0t: bus answer never came", $time);
            fail_count++;
            summarize();
        end
    endtask : tick

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] exp);
        int   n;
        logic done;
        n = 0;
        done = 1'h0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hF;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        while (!done)
        begin
            tick(n);
            if (awvalid && awready)
                awvalid <= 1'h0;
            if (wvalid && wready)
                wvalid <= 1'h0;
            if (bvalid)
            begin
                done = 1'h1;
                bready <= 1'h0;
                check(bresp, exp, "write response");
            end
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, input logic [1:0] exp);
        int   n;
        logic done;
        n = 0;
        done = 1'h0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        while (!done)
        begin
            tick(n);
            if (arvalid && arready)
                arvalid <= 1'h0;
            if (rvalid)
            begin
                d = rdata;
                done = 1'h1;
                rready <= 1'h0;
                check(rresp, exp, "read response");
            end
        end
    endtask : axi_rd

    // Buttons and lockout are pressed then released; ext and ramp levels stay
    task automatic drive(input cmd_type p, input cmd_type r, input cmd_type e, input logic rmp, input logic lk);
        @(posedge aclk);
        panel_req  <= p;
        remote_req <= r;
        ext_req    <= e;
        ramp_end   <= rmp;
        lock_req   <= lk;
        repeat (20) @(posedge aclk);
        panel_req  <= NONE;
        remote_req <= NONE;
        lock_req   <= 1'h0;
        repeat (20) @(posedge aclk);
        @(negedge aclk);
    endtask : drive

    task automatic t_reset();
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        check({lsw, rsw, lamp_lk}, 3'h0, "outputs after reset");
        axi_rd(STATUS_OFFSET, stat, RESP_OKAY);
        check(stat[STAT_SIDE_BIT], 1'h1, "left side after reset");
        check(stat[STAT_LOCK_BIT], 1'h0, "lockout after reset");
        $display("Test reset done");
    endtask : t_reset

    task automatic t_regs();
        axi_rd(CTRL_OFFSET, stat, RESP_OKAY);
        check(stat, CTRL_RESET, "control reset value");
        axi_wr(CTRL_OFFSET, 32'hFFFF_FFFF, RESP_OKAY);
        axi_rd(CTRL_OFFSET, stat, RESP_OKAY);
        check(stat, 32'h0000_0001, "control writable bit");
        axi_wr(STATUS_OFFSET, 32'hFFFF_FFFF, RESP_OKAY);
        axi_wr(4'h8, 32'h0000_0001, RESP_DECERR);
        axi_rd(4'hC, stat, RESP_DECERR);
        check(stat, 32'h0000_0000, "unmapped read data");
        axi_wr(CTRL_OFFSET, 32'h0000_0000, RESP_OKAY);
        $display("Test registers done");
    endtask : t_regs

    task automatic t_synth();
        drive(SR, NONE, NONE, 1'h0, 1'h0);
        check(outs, 7'h28, "synth right");
        drive(NONE, SL, NONE, 1'h0, 1'h0);
        check(outs, 7'h50, "remote synth left");
        axi_rd(STATUS_OFFSET, stat, RESP_OKAY);
        check(stat[STAT_SIDE_BIT], 1'h1, "side follows left latch");
        drive(SR, NONE, NONE, 1'h0, 1'h0);
        axi_rd(STATUS_OFFSET, stat, RESP_OKAY);
        check(stat[STAT_SIDE_BIT], 1'h0, "side follows right latch");
        $display("Test synth done");
    endtask : t_synth

    task automatic t_bypass();
        drive(NONE, BY, NONE, 1'h0, 1'h0);
        check(outs, 7'h24, "bypass holds right switch");
        drive(NONE, NONE, NONE, 1'h1, 1'h0);
        check(outs, 7'h04, "ramp done opens switches");
        drive(SL, NONE, NONE, 1'h0, 1'h0);
        check(outs, 7'h50, "synth left after bypass");
        $display("Test bypass done");
    endtask : t_bypass

    task automatic t_direct();
        axi_wr(CTRL_OFFSET, 32'h0000_0001, RESP_OKAY);
        drive(NONE, NONE, BY, 1'h0, 1'h0);
        check(outs, 7'h44, "direct bypass keeps left");
        axi_rd(STATUS_OFFSET, stat, RESP_OKAY);
        check(stat[STAT_DIRECT_BIT], 1'h1, "direct path chosen");
        drive(NONE, NONE, BY, 1'h1, 1'h0);
        check(outs, 7'h04, "direct ramp done");
        drive(NONE, NONE, SR, 1'h0, 1'h0);
        check(outs, 7'h28, "direct synth right");
        drive(NONE, NONE, NONE, 1'h0, 1'h0);
        check(outs, 7'h50, "back to latch source");
        axi_wr(CTRL_OFFSET, 32'h0000_0000, RESP_OKAY);
        $display("Test direct done");
    endtask : t_direct

    task automatic t_lockout();
        drive(NONE, NONE, NONE, 1'h0, 1'h1);
        check(outs, 7'h51, "one bouncy press toggles once");
        drive(NONE, NONE, SR, 1'h0, 1'h0);
        check(outs, 7'h51, "external ignored");
        drive(NONE, NONE, 4'h3, 1'h0, 1'h0);
        check(outs, 7'h51, "no auto while locked");
        axi_rd(STATUS_OFFSET, stat, RESP_OKAY);
        check(stat[STAT_FAULT_BIT], 1'h0, "no fault while locked");
        drive(NONE, NONE, NONE, 1'h0, 1'h1);
        check(outs, 7'h50, "second press unlocks");
        $display("Test lockout done");
    endtask : t_lockout

    task automatic t_fault();
        drive(NONE, NONE, SR, 1'h0, 1'h0);
        check(outs, 7'h28, "external reaches latches");
        drive(NONE, NONE, 4'h3, 1'h0, 1'h0);
        check(outs[1], 1'h1, "fault forces auto");
        axi_rd(STATUS_OFFSET, stat, RESP_OKAY);
        check(stat[STAT_FAULT_BIT], 1'h1, "fault seen");
        drive(SR, NONE, NONE, 1'h0, 1'h0);
        check(outs, 7'h28, "button clears auto");
        drive(AU, NONE, NONE, 1'h0, 1'h0);
        check(outs[1], 1'h1, "auto lamp");
        $display("Test fault done");
    endtask : t_fault

    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset();
        t_regs();
        t_synth();
        t_bypass();
        t_direct();
        t_lockout();
        t_fault();
        summarize();
    end
endmodule : tb
